// file: pkg/srpc_map.vh
/*
  Constants for the command, refresh and power-state block of a four-bank DDR memory.
  Assumes the includer uses them at the widths given here.
*/
`ifndef SRPC_MAP_VH
`define SRPC_MAP_VH

// Command codes from {ras_n, cas_n, we_n}
`define SRPC_CMD_NOP      3'h7
`define SRPC_CMD_ACT      3'h3
`define SRPC_CMD_REF      3'h1
`define SRPC_CMD_MRS      3'h0
`define SRPC_CMD_RD       3'h5
`define SRPC_CMD_WR       3'h4
`define SRPC_CMD_PRE      3'h2
`define SRPC_CMD_BST      3'h6

// Decoded command index
`define SRPC_DC_DESEL     4'h0
`define SRPC_DC_NOP       4'h1
`define SRPC_DC_ACT       4'h2
`define SRPC_DC_REF       4'h3
`define SRPC_DC_MRS       4'h4
`define SRPC_DC_RD        4'h5
`define SRPC_DC_WR        4'h6
`define SRPC_DC_PRE       4'h7
`define SRPC_DC_BST       4'h8
`define SRPC_DC_SREF      4'h9

// Device power states
`define SRPC_PS_NORMAL    2'h0
`define SRPC_PS_PDN_PRE   2'h1
`define SRPC_PS_PDN_ACT   2'h2
`define SRPC_PS_SREF      2'h3

// Bank states
`define SRPC_BS_IDLE      3'h0
`define SRPC_BS_ACTVING   3'h1
`define SRPC_BS_ACTIVE    3'h2
`define SRPC_BS_READ      3'h3
`define SRPC_BS_WRITE     3'h4
`define SRPC_BS_PRECHG    3'h5

// Timing in ns at a 100 ns clock
`define SRPC_CLK_NS       100
`define SRPC_TRP_NS       300
`define SRPC_TRCD_NS      300
`define SRPC_TRFC_NS      1000
`define SRPC_TMRD_NS      200
`define SRPC_CYC_MIN(ns)  (((ns) + `SRPC_CLK_NS - 1) / `SRPC_CLK_NS)
`define SRPC_TRP_CYC      `SRPC_CYC_MIN(`SRPC_TRP_NS)
`define SRPC_TRCD_CYC     `SRPC_CYC_MIN(`SRPC_TRCD_NS)
`define SRPC_TRFC_CYC     `SRPC_CYC_MIN(`SRPC_TRFC_NS)
`define SRPC_TMRD_CYC     `SRPC_CYC_MIN(`SRPC_TMRD_NS)
`define SRPC_DLL_CYC      200

`endif

// file: core/srpc_bank.v
/*
  One bank's state tracker: idle, activating, active, read, write, precharging.
  Assumes commands arrive already decoded and addressed to this bank, one per clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srpc_map.vh"

module srpc_bank #(
  parameter TRP_CYC  = `SRPC_TRP_CYC,
  parameter TRCD_CYC = `SRPC_TRCD_CYC,
  parameter BURST    = 4
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       cmd_act,
  input  wire       cmd_rd,
  input  wire       cmd_wr,
  input  wire       cmd_pre,
  input  wire       burst_end,
  input  wire       force_idle,
  output wire [2:0] bank_state,
  output wire       bank_idle,
  output wire       bank_open
);

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;

  assign bank_state = state_reg;
  assign bank_idle  = (state_reg == `SRPC_BS_IDLE);
  assign bank_open  = (state_reg != `SRPC_BS_IDLE) && (state_reg != `SRPC_BS_PRECHG);

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    if (force_idle) begin
      state_next = `SRPC_BS_IDLE;
      cnt_next   = 8'h00;
    end else begin
      case (state_reg)
        `SRPC_BS_IDLE: begin
          if (cmd_act) begin
            state_next = `SRPC_BS_ACTVING;
            cnt_next   = TRCD_CYC[7:0] - 8'h01;
          end
        end
        `SRPC_BS_ACTVING: begin
          if (cnt_reg == 8'h00)
            state_next = `SRPC_BS_ACTIVE;
        end
        `SRPC_BS_ACTIVE, `SRPC_BS_READ, `SRPC_BS_WRITE: begin
          if (cmd_pre) begin
            state_next = `SRPC_BS_PRECHG;
            cnt_next   = TRP_CYC[7:0] - 8'h01;
          end else if (cmd_rd) begin
            state_next = `SRPC_BS_READ;
            cnt_next   = BURST[7:0];
          end else if (cmd_wr) begin
            state_next = `SRPC_BS_WRITE;
            cnt_next   = BURST[7:0];
          end else if (state_reg != `SRPC_BS_ACTIVE && (burst_end || cnt_reg == 8'h00)) begin
            state_next = `SRPC_BS_ACTIVE;
          end
        end
        `SRPC_BS_PRECHG: begin
          if (cnt_reg == 8'h00)
            state_next = `SRPC_BS_IDLE;
        end
        default: state_next = `SRPC_BS_IDLE;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `SRPC_BS_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// file: core/srpc_core.v
/*
  Command decode, auto/self refresh, power-down and per-bank legality for a
  four-bank DDR memory. Assumes all inputs are synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srpc_map.vh"

// Behaviour
// - CS, RAS, CAS low with CKE and WE high decodes as auto refresh.
// - Refresh row comes from internal counter; external address is ignored.
// - After refresh all banks idle; controller waits refresh cycle time.
// - Refresh decode with CKE low enters self refresh.
// - Self refresh holds while CKE low; all other inputs ignored.
// - Internal clock is gated off during self refresh.
// - CKE registered low with no access enters precharge or active power-down.
// - In power-down buffers are off and inputs other than CKE ignored.
// - CKE high with NOP or deselect exits power-down synchronously.
// - CKE falling with NOP picks power-down kind; with refresh enters self refresh.
// - CS high is deselect; low decodes RAS, CAS, WE into eight commands.
// - Bank idle after precharge period; active after activate-to-column delay.
// - Read burst accepts read, write, burst stop or truncating precharge.
// - Write burst accepts write, read or truncating precharge.
// - Other banks accept activate, read, write, precharge in parallel.
// - Burst stop ends the most recent read burst, any bank.
module srpc_core #(
  parameter ROW_W    = 13,
  parameter TRFC_CYC = `SRPC_TRFC_CYC,
  parameter TMRD_CYC = `SRPC_TMRD_CYC,
  parameter DLL_CYC  = `SRPC_DLL_CYC,
  parameter BURST    = 4
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             cke,
  input  wire             cs_n,
  input  wire             ras_n,
  input  wire             cas_n,
  input  wire             we_n,
  input  wire [1:0]       bank_addr,
  input  wire             pre_all,
  output reg  [3:0]       cmd_code,
  output reg  [1:0]       power_state,
  output reg              internal_clk_en,
  output reg              input_buf_en,
  output reg              refresh_busy,
  output reg              refresh_pulse,
  output reg  [ROW_W-1:0] refresh_row,
  output reg              dll_locking,
  output reg  [3:0]       bank_idle_mask,
  output reg  [3:0]       bank_open_mask,
  output reg              cmd_illegal,
  output reg              read_burst_valid,
  output reg  [1:0]       read_burst_bank
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function [3:0] decode_cmd;
    input cs;
    input [2:0] rcw;
    begin
      if (cs)
        decode_cmd = `SRPC_DC_DESEL;
      else begin
        case (rcw)
          `SRPC_CMD_NOP: decode_cmd = `SRPC_DC_NOP;
          `SRPC_CMD_ACT: decode_cmd = `SRPC_DC_ACT;
          `SRPC_CMD_REF: decode_cmd = `SRPC_DC_REF;
          `SRPC_CMD_MRS: decode_cmd = `SRPC_DC_MRS;
          `SRPC_CMD_RD:  decode_cmd = `SRPC_DC_RD;
          `SRPC_CMD_WR:  decode_cmd = `SRPC_DC_WR;
          `SRPC_CMD_PRE: decode_cmd = `SRPC_DC_PRE;
          `SRPC_CMD_BST: decode_cmd = `SRPC_DC_BST;
          default:       decode_cmd = `SRPC_DC_NOP;
        endcase
      end
    end
  endfunction

  reg        cke_prev_reg;
  reg [1:0]  pstate_reg;
  reg [1:0]  pstate_next;
  reg [7:0]  busy_cnt_reg;
  reg [7:0]  busy_cnt_next;
  reg [7:0]  dll_cnt_reg;
  reg [7:0]  dll_cnt_next;
  reg [ROW_W-1:0] row_cnt_reg;
  reg [2:0]  rd_left_reg;
  reg [2:0]  rd_left_next;
  reg [1:0]  rd_bank_reg;
  reg [1:0]  rd_bank_next;

  wire [3:0] raw_cmd = decode_cmd(cs_n, {ras_n, cas_n, we_n});
  wire       nop_like = (raw_cmd == `SRPC_DC_DESEL) || (raw_cmd == `SRPC_DC_NOP);
  wire       in_normal = (pstate_reg == `SRPC_PS_NORMAL);
  wire [3:0] b_idle;
  wire [3:0] b_open;
  wire [11:0] b_state;
  wire       all_idle = &b_idle;
  wire       any_burst;
  wire       busy = (busy_cnt_reg != 8'h00);

  // Commands only reach the core with CKE high on both edges and no refresh or mode set running
  wire live = in_normal && cke_prev_reg && cke && !busy;
  wire [3:0] cmd_eff = live ? raw_cmd : `SRPC_DC_NOP;

  wire do_ref  = (cmd_eff == `SRPC_DC_REF) && all_idle;
  wire do_mrs  = (cmd_eff == `SRPC_DC_MRS) && all_idle;
  wire do_bst  = (cmd_eff == `SRPC_DC_BST) && (rd_left_reg != 3'h0);
  wire sref_in = in_normal && cke_prev_reg && !cke && (raw_cmd == `SRPC_DC_REF) && all_idle && !busy;
  wire pdn_in  = in_normal && cke_prev_reg && !cke && nop_like && !any_burst && !busy;

  ////////////////////////////////////////////////////////////////////////////
  // Banks
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      wire sel = (bank_addr == gi[1:0]);
      srpc_bank #(
        .BURST (BURST)
      ) u_bank (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .cmd_act    (sel && cmd_eff == `SRPC_DC_ACT),
        .cmd_rd     (sel && cmd_eff == `SRPC_DC_RD),
        .cmd_wr     (sel && cmd_eff == `SRPC_DC_WR),
        .cmd_pre    ((sel || pre_all) && cmd_eff == `SRPC_DC_PRE),
        .burst_end  (do_bst && rd_bank_reg == gi[1:0]),
        .force_idle (do_ref),
        .bank_state (b_state[3*gi +: 3]),
        .bank_idle  (b_idle[gi]),
        .bank_open  (b_open[gi])
      );
    end
  endgenerate

  assign any_burst = (b_state[2:0]  == `SRPC_BS_READ) || (b_state[2:0]  == `SRPC_BS_WRITE) ||
                     (b_state[5:3]  == `SRPC_BS_READ) || (b_state[5:3]  == `SRPC_BS_WRITE) ||
                     (b_state[8:6]  == `SRPC_BS_READ) || (b_state[8:6]  == `SRPC_BS_WRITE) ||
                     (b_state[11:9] == `SRPC_BS_READ) || (b_state[11:9] == `SRPC_BS_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // Power state and busy timers
  always @* begin
    pstate_next   = pstate_reg;
    busy_cnt_next = busy ? busy_cnt_reg - 8'h01 : 8'h00;
    dll_cnt_next  = (dll_cnt_reg != 8'h00) ? dll_cnt_reg - 8'h01 : 8'h00;
    case (pstate_reg)
      `SRPC_PS_NORMAL: begin
        if (sref_in)
          pstate_next = `SRPC_PS_SREF;
        else if (pdn_in)
          pstate_next = (|b_open) ? `SRPC_PS_PDN_ACT : `SRPC_PS_PDN_PRE;
        else if (do_ref)
          busy_cnt_next = TRFC_CYC[7:0] - 8'h01;
        else if (do_mrs)
          busy_cnt_next = TMRD_CYC[7:0] - 8'h01;
      end
      `SRPC_PS_PDN_PRE, `SRPC_PS_PDN_ACT: begin
        if (cke && nop_like)
          pstate_next = `SRPC_PS_NORMAL;
      end
      `SRPC_PS_SREF: begin
        if (cke && nop_like) begin
          pstate_next  = `SRPC_PS_NORMAL;
          dll_cnt_next = DLL_CYC[7:0];
        end
      end
      default: pstate_next = `SRPC_PS_NORMAL;
    endcase
  end

  // Most recent read burst, for bank-independent burst stop
  always @* begin
    rd_left_next = (rd_left_reg != 3'h0) ? rd_left_reg - 3'h1 : 3'h0;
    rd_bank_next = rd_bank_reg;
    if (cmd_eff == `SRPC_DC_RD) begin
      rd_left_next = BURST[2:0];
      rd_bank_next = bank_addr;
    end else if (do_bst || cmd_eff == `SRPC_DC_WR) begin
      rd_left_next = 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_reg <= 1'b0;
      pstate_reg   <= `SRPC_PS_NORMAL;
      busy_cnt_reg <= 8'h00;
      dll_cnt_reg  <= 8'h00;
      row_cnt_reg  <= {ROW_W{1'b0}};
      rd_left_reg  <= 3'h0;
      rd_bank_reg  <= 2'h0;
    end else begin
      cke_prev_reg <= cke;
      pstate_reg   <= pstate_next;
      busy_cnt_reg <= busy_cnt_next;
      dll_cnt_reg  <= dll_cnt_next;
      rd_left_reg  <= rd_left_next;
      rd_bank_reg  <= rd_bank_next;
      // Self refresh also walks the row counter so no row starves
      if (do_ref || (pstate_reg == `SRPC_PS_SREF && !cke))
        row_cnt_reg <= row_cnt_reg + {{(ROW_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code         <= `SRPC_DC_DESEL;
      power_state      <= `SRPC_PS_NORMAL;
      internal_clk_en  <= 1'b1;
      input_buf_en     <= 1'b1;
      refresh_busy     <= 1'b0;
      refresh_pulse    <= 1'b0;
      refresh_row      <= {ROW_W{1'b0}};
      dll_locking      <= 1'b0;
      bank_idle_mask   <= 4'hf;
      bank_open_mask   <= 4'h0;
      cmd_illegal      <= 1'b0;
      read_burst_valid <= 1'b0;
      read_burst_bank  <= 2'h0;
    end else begin
      cmd_code         <= sref_in ? `SRPC_DC_SREF : cmd_eff;
      power_state      <= pstate_next;
      internal_clk_en  <= (pstate_next != `SRPC_PS_SREF);
      input_buf_en     <= (pstate_next == `SRPC_PS_NORMAL);
      refresh_busy     <= (busy_cnt_next != 8'h00) && do_ref || (refresh_busy && busy);
      refresh_pulse    <= do_ref;
      refresh_row      <= do_ref ? row_cnt_reg : refresh_row;
      dll_locking      <= (dll_cnt_next != 8'h00);
      bank_idle_mask   <= b_idle;
      bank_open_mask   <= b_open;
      // Flags a command the state tables do not allow; it never blocks anything else
      cmd_illegal      <= (live && ((raw_cmd == `SRPC_DC_REF || raw_cmd == `SRPC_DC_MRS) && !all_idle ||
                           raw_cmd == `SRPC_DC_BST && rd_left_reg == 3'h0)) ||
                          (in_normal && cke_prev_reg && cke && busy && !nop_like);
      read_burst_valid <= (rd_left_next != 3'h0);
      read_burst_bank  <= rd_bank_next;
    end
  end

endmodule
`default_nettype wire

// file: verification/srpc_core_checker.sv
/*
  Port assertions for srpc_core: decode, refresh, self refresh, power-down.
  Assumes it is bound to srpc_core, one clock and an async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srpc_map.vh"
module srpc_core_checker #(
  parameter ROW_W = 13
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic             cke,
  input wire logic             cs_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic [1:0]       bank_addr,
  input wire logic             pre_all,
  input wire logic [3:0]       cmd_code,
  input wire logic [1:0]       power_state,
  input wire logic             internal_clk_en,
  input wire logic             input_buf_en,
  input wire logic             refresh_busy,
  input wire logic             refresh_pulse,
  input wire logic [ROW_W-1:0] refresh_row,
  input wire logic             dll_locking,
  input wire logic [3:0]       bank_idle_mask,
  input wire logic [3:0]       bank_open_mask,
  input wire logic             cmd_illegal,
  input wire logic             read_burst_valid,
  input wire logic [1:0]       read_burst_bank
);
  wire logic [2:0] rcw = {ras_n, cas_n, we_n};
  wire logic nop_ok = cs_n || rcw == `SRPC_CMD_NOP;
  wire logic pdn = power_state == `SRPC_PS_PDN_PRE || power_state == `SRPC_PS_PDN_ACT;
  // Clocks since a read or write showed on cmd_code; a burst keeps its bank busy four more clocks
  logic [2:0] acc_age;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_age <= 3'h7;
    end else if (cmd_code == `SRPC_DC_RD || cmd_code == `SRPC_DC_WR) begin
      acc_age <= 3'h0;
    end else if (acc_age != 3'h7) begin
      acc_age <= acc_age + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////
  // A command counts only once the device is awake and settled; a mode set holds the core one more clock
  sequence s_hi;
    $past(cke) && cke && power_state == `SRPC_PS_NORMAL && !refresh_busy && !dll_locking &&
      cmd_code != `SRPC_DC_MRS;
  endsequence
  sequence s_fall;
    $past(cke) && !cke && power_state == `SRPC_PS_NORMAL && !refresh_busy && !dll_locking &&
      cmd_code != `SRPC_DC_MRS;
  endsequence
  // The bank masks lag the banks by a clock, so the mask one clock on shows what the core judged
  property p_ref_decode;
    s_hi ##0 !cs_n && rcw == `SRPC_CMD_REF
      |=> bank_idle_mask != 4'hf || (refresh_pulse && cmd_code == `SRPC_DC_REF);
  endproperty
  a_ref_decode: assert property (p_ref_decode) else $error("refresh not decoded");
  property p_ref_busy;
    refresh_pulse |-> refresh_busy [*8] ##[1:4] (!refresh_busy && bank_idle_mask == 4'hf);
  endproperty
  a_ref_busy: assert property (p_ref_busy) else $error("refresh busy span wrong");
  property p_ref_row;
    $changed(refresh_row) |-> refresh_pulse || power_state == `SRPC_PS_SREF || $past(power_state) == `SRPC_PS_SREF;
  endproperty
  a_ref_row: assert property (p_ref_row) else $error("refresh row moved outside refresh");
  property p_ref_refuse;
    s_hi ##0 !cs_n && rcw == `SRPC_CMD_REF |=> bank_idle_mask == 4'hf || (cmd_illegal && !refresh_pulse);
  endproperty
  a_ref_refuse: assert property (p_ref_refuse) else $error("refresh taken with open bank");
  property p_sref_entry;
    s_fall ##0 !cs_n && rcw == `SRPC_CMD_REF
      |=> bank_idle_mask != 4'hf || (power_state == `SRPC_PS_SREF && !internal_clk_en && !input_buf_en);
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");
  property p_sref_hold;
    power_state == `SRPC_PS_SREF && !cke
      |=> power_state == `SRPC_PS_SREF && !internal_clk_en && cmd_code == `SRPC_DC_NOP;
  endproperty
  a_sref_hold: assert property (p_sref_hold) else $error("self refresh left or input seen");
  property p_sref_exit;
    power_state == `SRPC_PS_SREF && cke && nop_ok |=> power_state == `SRPC_PS_NORMAL && dll_locking;
  endproperty
  a_sref_exit: assert property (p_sref_exit) else $error("self refresh exit wrong");
  property p_pdn_entry;
    s_fall ##0 nop_ok && !read_burst_valid && acc_age >= 3'h4 && cmd_code != `SRPC_DC_RD && cmd_code != `SRPC_DC_WR
      |=> power_state == (bank_open_mask != 4'h0 ? `SRPC_PS_PDN_ACT : `SRPC_PS_PDN_PRE);
  endproperty
  a_pdn_entry: assert property (p_pdn_entry) else $error("power-down kind wrong");
  property p_pdn_hold;
    pdn && !cke |=> $stable(power_state) && !input_buf_en && cmd_code == `SRPC_DC_NOP;
  endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("power-down not held");
  property p_pdn_exit;
    pdn && cke && nop_ok |=> power_state == `SRPC_PS_NORMAL && input_buf_en;
  endproperty
  a_pdn_exit: assert property (p_pdn_exit) else $error("power-down exit wrong");
  property p_desel;
    s_hi ##0 cs_n |=> cmd_code == `SRPC_DC_DESEL;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect not decoded");
  property p_bst_stray;
    s_hi ##0 !cs_n && rcw == `SRPC_CMD_BST && !read_burst_valid |=> cmd_illegal;
  endproperty
  a_bst_stray: assert property (p_bst_stray) else $error("burst stop without read not flagged");
endmodule
`default_nettype wire

// file: verification/srpc_ctrl_model.sv
/*
  Behavioural memory controller driving the command pins of srpc_core.
  Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module srpc_ctrl_model (
  input  wire logic       core_clk,
  output var  logic       cke,
  output var  logic       cs_n,
  output var  logic       ras_n,
  output var  logic       cas_n,
  output var  logic       we_n,
  output var  logic [1:0] bank_addr,
  output var  logic       pre_all
);
  localparam logic [11:0] NOP = 12'h700;
  initial begin
    cke = 1'h1;
    {cs_n, ras_n, cas_n, we_n, bank_addr, pre_all} = NOP[11:5];
  end
  //////////////////////////////////////////
  task automatic step(input logic k, input logic [11:0] r);
    {cs_n, ras_n, cas_n, we_n, bank_addr, pre_all} = r[11:5];
    cke = k;
    @(posedge core_clk);
    #1;
  endtask
  // Clock never stops here, so the exit only needs the NOP lead-in
  task automatic sref_exit(input int dll);
    step(1'h0, NOP);
    step(1'h1, NOP);
    repeat (dll + 2) step(1'h1, NOP);
    step(1'h1, 12'h103);
  endtask
endmodule
`default_nettype wire

// file: verification/srpc_core_test.sv
/*
  Self-checking bench for srpc_core: command table, then refresh and power cases.
  Assumes srpc_map.vh on the include path; the DLL wait is shortened to 8 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srpc_map.vh"
module srpc_core_test;
  localparam int DLL = 8;
  localparam logic [11:0] NOP = 12'h700;
  // Low nibble of each row is the expected decoded command
  localparam logic [11:0] ROWS [0:22] = '{12'h302, 12'h701, 12'h701, 12'h701, 12'h505, 12'h608, 12'h406, 12'h505,
    12'h342, 12'h207, 12'h701, 12'h701, 12'h701, 12'h267, 12'h701, 12'h701, 12'h701, 12'h701, 12'h004,
    12'h701, 12'h701, 12'hf00, 12'h103};
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  wire cke, cs_n, ras_n, cas_n, we_n, pre_all;
  wire [1:0] bank_addr;
  logic [3:0] cmd_code, bank_idle_mask, bank_open_mask;
  logic [1:0] power_state, read_burst_bank;
  logic [12:0] refresh_row;
  logic internal_clk_en, input_buf_en, refresh_busy, refresh_pulse, dll_locking, cmd_illegal, read_burst_valid;
  int mismatches = 0;
  int num_checks = 0;
  logic [15:0] cycles = 16'h0;
  logic [15:0] dll_cnt = 16'h0;
  always #50 core_clk = ~core_clk;
  srpc_ctrl_model srpc_ctrl_model_inst (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .pre_all(pre_all));
  srpc_core #(.DLL_CYC(DLL)) srpc_core_inst (.core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .pre_all(pre_all), .cmd_code(cmd_code),
    .power_state(power_state), .internal_clk_en(internal_clk_en), .input_buf_en(input_buf_en),
    .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
    .dll_locking(dll_locking), .bank_idle_mask(bank_idle_mask), .bank_open_mask(bank_open_mask),
    .cmd_illegal(cmd_illegal), .read_burst_valid(read_burst_valid), .read_burst_bank(read_burst_bank));
  //////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic step(input logic k, input logic [11:0] r);
    srpc_ctrl_model_inst.step(k, r);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is under 200 cycles; the ceiling only catches a hang
  always @(posedge core_clk) begin
    cycles <= cycles + 16'h1;
    if (dll_locking === 1'h1) begin
      dll_cnt <= dll_cnt + 16'h1;
    end
    if (cycles == 16'h7d0) begin
      mismatches++;
      tally_and_finish;
    end
  end
  //////////////////////////////////////////
  initial begin
    logic [12:0] row_a;
    int n;
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    repeat (3) step(1'h1, NOP);
    check({power_state, bank_idle_mask, internal_clk_en, input_buf_en}, 8'h3f, "state after reset");
    foreach (ROWS[i]) begin
      step(1'h1, ROWS[i]);
      check(cmd_code, ROWS[i][3:0], "decoded command");
    end
    check(refresh_pulse, 1'h1, "refresh pulse");
    row_a = refresh_row;
    step(1'h1, 12'h1c3);
    check({cmd_illegal, cmd_code}, {1'h1, `SRPC_DC_NOP}, "refresh while busy");
    n = 1;
    while (refresh_busy === 1'h1 && n < 20) begin
      step(1'h1, NOP);
      n++;
    end
    check(n[15:0], 16'(`SRPC_TRFC_CYC), "refresh busy length");
    check(bank_idle_mask, 4'hf, "idle after refresh");
    step(1'h1, 12'h382);
    repeat (4) step(1'h1, NOP);
    check(bank_open_mask, 4'h4, "row open in bank two");
    step(1'h1, 12'h585);
    check({read_burst_valid, read_burst_bank}, 3'h6, "latest read burst");
    repeat (4) step(1'h1, NOP);
    step(1'h1, 12'h103);
    check({cmd_illegal, refresh_pulse}, 2'h2, "refresh with open row");
    step(1'h0, NOP);
    check({power_state, input_buf_en}, {`SRPC_PS_PDN_ACT, 1'h0}, "active power-down");
    step(1'h0, 12'h103);
    check({power_state, cmd_code}, {`SRPC_PS_PDN_ACT, `SRPC_DC_NOP}, "inputs ignored");
    step(1'h1, NOP);
    check(power_state, `SRPC_PS_NORMAL, "power-down exit");
    step(1'h1, NOP);
    step(1'h1, 12'h287);
    repeat (4) step(1'h1, NOP);
    step(1'h0, NOP);
    check(power_state, `SRPC_PS_PDN_PRE, "precharge power-down");
    step(1'h1, NOP);
    step(1'h1, NOP);
    step(1'h1, 12'h608);
    check(cmd_illegal, 1'h1, "stray burst stop");
    step(1'h1, NOP);
    step(1'h0, 12'h103);
    check({power_state, internal_clk_en, input_buf_en}, {`SRPC_PS_SREF, 2'h0}, "self refresh entry");
    repeat (2) step(1'h0, 12'h302);
    check({power_state, cmd_code}, {`SRPC_PS_SREF, `SRPC_DC_NOP}, "self refresh hold");
    srpc_ctrl_model_inst.sref_exit(DLL);
    check(dll_cnt, 16'h8, "lock wait length");
    check({power_state, refresh_pulse}, {`SRPC_PS_NORMAL, 1'h1}, "refresh after exit");
    check(refresh_row != row_a, 1'h1, "internal row advanced");
    tally_and_finish;
  end
endmodule
bind srpc_core srpc_core_checker #(.ROW_W(ROW_W)) srpc_core_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .pre_all(pre_all),
  .cmd_code(cmd_code), .power_state(power_state), .internal_clk_en(internal_clk_en), .input_buf_en(input_buf_en),
  .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
  .dll_locking(dll_locking), .bank_idle_mask(bank_idle_mask), .bank_open_mask(bank_open_mask),
  .cmd_illegal(cmd_illegal), .read_burst_valid(read_burst_valid), .read_burst_bank(read_burst_bank));
`default_nettype wire
